// File: hdl/fsap_pkg.sv
/*
  Constants, register map and state encoding for the fast-settling averaging postfilter.
  Assumes a single 100 MHz APB clock that also serves as the modulator master clock.
*/
package fsap_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned RES_W       = 24;
  localparam int unsigned RATE_W      = 10;
  localparam int unsigned WIN_W       = 20;
  localparam int unsigned ACC_W       = 21;
  localparam int unsigned SUM_W       = 25;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned CNT_W       = 5;

  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] DATA_ADDR   = 12'h008;

  localparam int unsigned CTRL_AVG_LSB  = 0;
  localparam int unsigned CTRL_SINC3    = 2;
  localparam int unsigned CTRL_CHOP     = 3;
  localparam int unsigned CTRL_SIXTY_HZ_NOTCH_ENABLE    = 4;
  localparam int unsigned CTRL_ENABLE   = 5;
  localparam int unsigned CTRL_CHAN_LSB = 8;
  localparam int unsigned CTRL_RATE_LSB = 16;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0060_0000;

  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_AVAIL   = 1;
  localparam int unsigned STAT_FULL    = 2;
  localparam int unsigned STAT_HOLD    = 3;
  localparam int unsigned STAT_CNT_LSB = 8;

  localparam int unsigned RES_CHAN_LSB = 24;
  localparam int unsigned WIN_SHIFT    = 10;

  localparam logic [1:0] AVG_OFF = 2'h0;
  localparam logic [1:0] AVG_2   = 2'h1;
  localparam logic [1:0] AVG_8   = 2'h2;
  localparam logic [1:0] AVG_16  = 2'h3;

  localparam logic [4:0] FILL_SINC4 = 5'h3;
  localparam logic [4:0] FILL_SINC3 = 5'h2;

  typedef enum logic [1:0] {
    FSAP_IDLE = 2'b00,
    FSAP_FILL = 2'b01,
    FSAP_AVG  = 2'b10,
    FSAP_HOLD = 2'b11
  } fsap_state_t;
endpackage : fsap_pkg

// File: hdl/fsap_fifo.sv
/*
  Flip-flop FIFO with valid and ready on both sides.
  Assumes both sides share one clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fsap_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output var  logic                     in_ready,
  output var  logic [WIDTH-1:0]         out_data,
  output var  logic                     out_valid,
  input  wire logic                     out_ready,
  output var  logic [$clog2(DEPTH):0]   count
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] wr_d;
  logic [PTR_W-1:0] rd_q;
  logic [PTR_W-1:0] rd_d;
  logic [PTR_W:0]   cnt_q;
  logic [PTR_W:0]   cnt_d;
  logic             push;
  logic             pop;

  // ==========================================================
  // Next state.
  always_comb begin
    push  = in_valid && (cnt_q != PTR_W'(0) + (PTR_W+1)'(DEPTH));
    pop   = out_ready && (cnt_q != '0);
    wr_d  = push ? wr_q + PTR_W'(1) : wr_q;
    rd_d  = pop ? rd_q + PTR_W'(1) : rd_q;
    cnt_d = cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  // ==========================================================
  // Registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (PTR_W+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
endmodule : fsap_fifo
`default_nettype wire

// File: hdl/fsap_top.sv
/*
  Fast-settling decimator with averaging postfilter, APB registers and result FIFO.
  Assumes the modulator bitstream pin is asynchronous and pclk is the master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fsap_top
  import fsap_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              modulator_bit,
  output var  logic              result_available
);

  // ==========================================================
  // Helper functions.
  function automatic logic [2:0] avg_shift(input logic [1:0] sel);
    unique case (sel)
      AVG_2:   avg_shift = 3'h1;
      AVG_8:   avg_shift = 3'h3;
      AVG_16:  avg_shift = 3'h4;
      AVG_OFF: avg_shift = 3'h0;
    endcase
  endfunction : avg_shift

  function automatic logic signed [ACC_W-1:0] half_sum(
    input logic signed [ACC_W-1:0] a,
    input logic signed [ACC_W-1:0] b
  );
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + {b[ACC_W-1], b};
    half_sum = s[ACC_W:1];
  endfunction : half_sum

  // ==========================================================
  // Pin synchroniser.
  logic mod_meta_q;
  logic mod_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_meta_q <= 1'b0;
      mod_sync_q <= 1'b0;
    end else begin
      mod_meta_q <= modulator_bit;
      mod_sync_q <= mod_meta_q;
    end
  end

  // ==========================================================
  // APB slave.
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic              restart;
  logic              fifo_pop;
  logic [DATA_W-1:0] fifo_out;
  logic              fifo_valid;
  logic              fifo_in_ready;
  logic [CNT_W-1:0]  fifo_count;
  logic [DATA_W-1:0] status_word;
  fsap_state_t       state_q;
  fsap_state_t       state_d;

  always_comb begin
    status_word = '0;
    status_word[STAT_BUSY]  = (state_q != FSAP_IDLE);
    status_word[STAT_AVAIL] = fifo_valid;
    status_word[STAT_FULL]  = !fifo_in_ready;
    status_word[STAT_HOLD]  = (state_q == FSAP_HOLD);
    status_word[STAT_CNT_LSB +: CNT_W] = fifo_count;
  end

  always_comb begin
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = 1'b0;
    restart   = 1'b0;
    fifo_pop  = 1'b0;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      prdata_d = '0;
      unique case (paddr)
        CTRL_ADDR: begin
          if (pwrite) begin
            ctrl_d  = pwdata;
            restart = 1'b1;
          end else begin
            prdata_d = ctrl_q;
          end
        end
        STATUS_ADDR: begin
          if (!pwrite) begin
            prdata_d = status_word;
          end
        end
        DATA_ADDR: begin
          if (!pwrite) begin
            prdata_d = fifo_valid ? fifo_out : '0;
            fifo_pop = fifo_valid;
          end
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RESET;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ==========================================================
  // Control fields.
  logic [1:0]        avg_sel;
  logic              fast_mode;
  logic              sinc3;
  logic              chop;
  logic              sixty_hz_notch_enable;
  logic              enable;
  logic [3:0]        channel;
  logic [RATE_W-1:0] rate_word;
  logic [WIN_W-1:0]  win_last;
  logic [4:0]        fill_last;
  logic [4:0]        avg_last;
  logic [2:0]        shift;

  always_comb begin
    avg_sel   = ctrl_q[CTRL_AVG_LSB +: 2];
    fast_mode = (avg_sel != AVG_OFF);
    sinc3     = ctrl_q[CTRL_SINC3];
    chop      = ctrl_q[CTRL_CHOP];
    sixty_hz_notch_enable     = ctrl_q[CTRL_SIXTY_HZ_NOTCH_ENABLE];
    enable    = ctrl_q[CTRL_ENABLE];
    channel   = ctrl_q[CTRL_CHAN_LSB +: 4];
    // unsigned rate word, zero is treated as one.
    rate_word = ctrl_q[CTRL_RATE_LSB +: RATE_W];
    if (rate_word == '0) begin
      rate_word = RATE_W'(1);
    end
    // sinc window of 1024 times rate word.
    win_last  = {rate_word, WIN_SHIFT'(0)} - WIN_W'(1);
    fill_last = (sinc3 ? FILL_SINC3 : FILL_SINC4) - 5'h1;
    shift     = avg_shift(avg_sel);
    avg_last  = 5'(5'h1 << shift) - 5'h1;
  end

  // ==========================================================
  // Conversion engine.
  logic [WIN_W-1:0]        win_q;
  logic [WIN_W-1:0]        win_d;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;
  logic [4:0]              nwin_q;
  logic [4:0]              nwin_d;
  logic signed [SUM_W-1:0] sum_q;
  logic signed [SUM_W-1:0] sum_d;
  logic signed [ACC_W-1:0] prev_win_q;
  logic signed [ACC_W-1:0] prev_win_d;
  logic signed [ACC_W-1:0] prev_conv_q;
  logic signed [ACC_W-1:0] prev_conv_d;
  logic                    phase_q;
  logic                    phase_d;
  logic                    first_q;
  logic                    first_d;
  logic [DATA_W-1:0]       res_q;
  logic [DATA_W-1:0]       res_d;
  logic                    push;
  logic [DATA_W-1:0]       push_data;
  logic signed [ACC_W-1:0] win_val;
  logic signed [ACC_W-1:0] term;
  logic signed [SUM_W-1:0] sum_all;
  logic signed [ACC_W-1:0] conv;
  logic signed [ACC_W-1:0] final_val;

  always_comb begin
    state_d     = state_q;
    win_d       = win_q;
    acc_d       = acc_q;
    nwin_d      = nwin_q;
    sum_d       = sum_q;
    prev_win_d  = prev_win_q;
    prev_conv_d = prev_conv_q;
    phase_d     = phase_q;
    first_d     = first_q;
    res_d       = res_q;
    push        = 1'b0;
    push_data   = res_q;
    win_val     = acc_q + ((mod_sync_q ^ phase_q) ? ACC_W'(1) : -ACC_W'(1));
    if (phase_q) begin
      win_val = -win_val;
    end
    // neighbour pairing adds a notch, window count unchanged.
    term      = sixty_hz_notch_enable ? half_sum(win_val, prev_win_q) : win_val;
    sum_all   = sum_q + SUM_W'(term);
    conv      = ACC_W'(sum_all >>> shift);
    final_val = chop ? half_sum(conv, prev_conv_q) : conv;
    if (state_q == FSAP_FILL || state_q == FSAP_AVG) begin
      win_d = win_q + WIN_W'(1);
      acc_d = acc_q + ((mod_sync_q ^ phase_q) ? ACC_W'(1) : -ACC_W'(1));
      if (win_q == win_last) begin
        win_d      = '0;
        acc_d      = '0;
        prev_win_d = win_val;
        nwin_d     = nwin_q + 5'h1;
        if (state_q == FSAP_FILL) begin
          if (nwin_q == fill_last) begin
            state_d = FSAP_AVG;
            nwin_d  = '0;
          end
        end else begin
          sum_d = sum_all;
          if (nwin_q == (fast_mode ? avg_last : 5'h0)) begin
            nwin_d      = '0;
            sum_d       = '0;
            prev_conv_d = conv;
            res_d       = '0;
            res_d[RES_W-1:0] = RES_W'(final_val);
            res_d[RES_CHAN_LSB +: 4] = channel;
            first_d     = 1'b0;
            if (chop) begin
              phase_d = !phase_q;
            end
            if (fast_mode) begin
              state_d = FSAP_FILL;
            end
            if (!(chop && first_q)) begin
              push = fifo_in_ready;
              push_data = res_d;
              if (!fifo_in_ready) begin
                state_d = FSAP_HOLD;
              end
            end
          end
        end
      end
    end else if (state_q == FSAP_HOLD) begin
      push      = fifo_in_ready;
      push_data = res_q;
      if (fifo_in_ready) begin
        state_d = fast_mode ? FSAP_FILL : FSAP_AVG;
      end
    end
    if (restart || (state_q == FSAP_IDLE && enable)) begin
      state_d     = ctrl_d[CTRL_ENABLE] ? FSAP_FILL : FSAP_IDLE;
      win_d       = '0;
      acc_d       = '0;
      nwin_d      = '0;
      sum_d       = '0;
      phase_d     = 1'b0;
      first_d     = 1'b1;
      prev_conv_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= FSAP_IDLE;
      win_q       <= '0;
      acc_q       <= '0;
      nwin_q      <= '0;
      sum_q       <= '0;
      prev_win_q  <= '0;
      prev_conv_q <= '0;
      phase_q     <= 1'b0;
      first_q     <= 1'b1;
      res_q       <= '0;
    end else begin
      state_q     <= state_d;
      win_q       <= win_d;
      acc_q       <= acc_d;
      nwin_q      <= nwin_d;
      sum_q       <= sum_d;
      prev_win_q  <= prev_win_d;
      prev_conv_q <= prev_conv_d;
      phase_q     <= phase_d;
      first_q     <= first_d;
      res_q       <= res_d;
    end
  end

  // ==========================================================
  // Result FIFO.
  logic avail_q;

  fsap_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_data   (push_data),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .count     (fifo_count)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avail_q <= 1'b0;
    end else begin
      avail_q <= fifo_valid;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign result_available = avail_q;
endmodule : fsap_top
`default_nettype wire

// File: sim/fsap_mod_model.sv
/*
  Modulator bitstream model: constant zeros, constant ones or alternating bits.
  Assumes the bench picks the pattern while no conversion is pending.
*/
`timescale 1ns/1ps
`default_nettype none
module fsap_mod_model (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output var  logic       bit_o
);
  logic tgl_q = 1'b0;

  always_ff @(posedge clk) tgl_q <= ~tgl_q;

  // Alternating bits sum to zero over any even window.
  assign bit_o = mode[1] ? tgl_q : mode[0];
endmodule : fsap_mod_model
`default_nettype wire

// File: sim/fsap_asserts.sv
/*
  Checker for fsap_top: APB answer timing and first-result timing.
  Assumes it is bound to fsap_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module fsap_asserts
  import fsap_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              modulator_bit,
  input wire logic              result_available
);
  logic        wr_ctrl;
  logic        map_hit;
  logic        first_q;
  logic        first_d;
  int unsigned cnt_q;
  int unsigned cnt_d;
  int unsigned per_q;
  int unsigned per_d;

  function automatic int unsigned per_of(input logic [DATA_W-1:0] c);
    int unsigned w;
    int unsigned o;
    int unsigned a;
    w = (c[CTRL_RATE_LSB+:RATE_W] == '0) ? 1 : int'(c[CTRL_RATE_LSB+:RATE_W]);
    w = 1024 * w;
    o = c[CTRL_SINC3] ? 3 : 4;
    a = (c[1:0] == AVG_2) ? 2 : (c[1:0] == AVG_8) ? 8 : 16;
    per_of = (c[1:0] == AVG_OFF) ? o * w : (o + a - 1) * w * (c[CTRL_CHOP] ? 2 : 1);
  endfunction : per_of

  assign wr_ctrl = psel && penable && pwrite && !pready && paddr == CTRL_ADDR;
  assign map_hit = paddr inside {CTRL_ADDR, STATUS_ADDR, DATA_ADDR};

  always_comb begin
    cnt_d   = wr_ctrl ? 0 : cnt_q + 1;
    per_d   = wr_ctrl ? per_of(pwdata) : per_q;
    first_d = (wr_ctrl ? pwdata[CTRL_ENABLE] : first_q) && !result_available;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 0;
      per_q   <= 0;
      first_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      per_q   <= per_d;
      first_q <= first_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_first_out;
    first_q && $rose(result_available);
  endsequence

  property p_ready_wait; s_access |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_ready_qual; pready |-> psel && penable && $past(psel && penable); endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("pready without access");
  property p_err_unmapped; pready && !map_hit |-> pslverr && prdata == '0; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_err_mapped; pready && map_hit |-> !pslverr; endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
  property p_prdata_hold; !psel |=> $stable(prdata); endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("prdata changed idle");
  // First result period.
  property p_avail_early; s_first_out |-> cnt_q + 2 >= per_q; endproperty
  a_avail_early: assert property (p_avail_early) else $error("result early");
  // Settles in one period.
  property p_avail_late; first_q |-> cnt_q <= per_q + 6; endproperty
  a_avail_late: assert property (p_avail_late) else $error("result late");
endmodule : fsap_asserts

bind fsap_top fsap_asserts i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .modulator_bit(modulator_bit), .result_available(result_available)
);
`default_nettype wire

// File: sim/tb_top.sv
/*
  Self-checking bench for fsap_top with a modulator model.
  Assumes fsap_pkg, a one-wait-state APB slave and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb_top
  import fsap_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic              mbit;
  logic              ravail;
  logic [1:0]        mode;
  logic [3:0]        ch;
  logic [ADDR_W-1:0] paddr;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] m;
  logic [DATA_W:0]   e;
  logic [DATA_W:0]   exp_q[$];
  logic [DATA_W-1:0] msk_q[$];
  int                n_mismatch;
  int                num_checks;
  int                i;

  always #5 pclk = ~pclk;

  fsap_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modulator_bit(mbit), .result_available(ravail)
  );
  fsap_mod_model i_mod (.clk(pclk), .mode(mode), .bit_o(mbit));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic hang;
    n_mismatch++;
    give_verdict();
  endtask : hang

  // =========================================================
  // APB master
  task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d,
                     input logic [DATA_W:0] x, input logic [DATA_W-1:0] k);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    exp_q.push_back(x);
    msk_q.push_back(k);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    apb(1'b1, ad, d, '0, '0);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] x,
                    input logic [DATA_W-1:0] k);
    apb(1'b0, ad, '0, {1'b0, x}, k);
  endtask : rd

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) `CHK("note", 1'b1, 1'b0)
      else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        `CHK("pslverr", e[DATA_W], pslverr)
        `CHK("prdata", e[DATA_W-1:0] & m, prdata & m)
      end
    end
  end

  // =========================================================
  // One conversion, restarted once on another channel
  task automatic conv(input logic [DATA_W-1:0] c, input logic [1:0] md, input logic [23:0] v,
                      input int p);
    int                n;
    logic [DATA_W-1:0] cc;
    ch = 4'($urandom());
    cc = c | (DATA_W'(ch) << CTRL_CHAN_LSB);
    mode <= md;
    wr(CTRL_ADDR, cc ^ 32'h0000_0500);
    repeat (p / 4) @(posedge pclk);
    wr(CTRL_ADDR, cc);
    n = 0;
    while (ravail !== 1'b1 && n < p + 20) begin
      @(posedge pclk);
      n++;
    end
    if (ravail !== 1'b1) hang();
    `CHK("period", 1'b1, n + 3 >= p && n <= p + 4)
    rd(DATA_ADDR, {4'h0, ch, v}, '1);
    wr(CTRL_ADDR, '0);
    $display("test conv %h done", c);
  endtask : conv

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mode = 2'h1;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h0917));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_ADDR, CTRL_RESET, '1);
    rd(STATUS_ADDR, '0, 32'h0000_1F0F);
    for (i = 0; i < 3; i++) begin
      a = (i == 0) ? 12'h00C : ADDR_W'(16 + 4 * ($urandom() % 1000));
      apb(i[0], a, '1, {1'b1, 32'h0}, '1);
    end
    wr(STATUS_ADDR, '1);
    rd(CTRL_ADDR, CTRL_RESET, '1);
    $display("test registers done");
    conv(32'h0002_0025, 2'h1, 24'h000800, 8192);
    conv(32'h0001_0036, 2'h2, 24'h000000, 10240);
    conv(32'h0001_0023, 2'h0, 24'hFFFC00, 19456);
    conv(32'h0001_003D, 2'h2, 24'h000000, 8192);
    mode <= 2'h2;
    wr(CTRL_ADDR, 32'h0001_0324);
    repeat (19 * 1024 + 200) @(posedge pclk);
    rd(STATUS_ADDR, 32'h0000_100E, 32'h0000_1F0E);
    wr(CTRL_ADDR, '0);
    for (i = 0; i < 16; i++) rd(DATA_ADDR, 32'h0300_0000, '1);
    rd(DATA_ADDR, '0, '1);
    `CHK("result_available", 1'b0, ravail)
    rd(STATUS_ADDR, '0, 32'h0000_1F07);
    $display("test fifo done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
